// >>> logic/sie_pkg.sv
// Purpose: Shared constants and types for the line interrupt status/enable block
// Assumes: 32-bit AHB-Lite register bus, one clock, async active-low reset
// Notes: Register offsets are word indices; byte address is four times the index
package sie_pkg;

    // ------------------------------------------------------------------
    // Register word indices
    // ------------------------------------------------------------------
    localparam logic [7:0] SIE_IDX_TIMER_PEND = 8'h12;  // Timer pending flags
    localparam logic [7:0] SIE_IDX_ALARM_PEND = 8'h13;  // Alarm / loop / ring trip flags
    localparam logic [7:0] SIE_IDX_CALIB_PEND = 8'h14;  // Calibration / indirect / tone flags
    localparam logic [7:0] SIE_IDX_TIMER_EN = 8'h15;    // Timer enables
    localparam logic [7:0] SIE_IDX_ALARM_EN = 8'h16;    // Alarm enables
    localparam logic [7:0] SIE_IDX_CALIB_EN = 8'h17;    // Calibration enables
    localparam logic [7:0] SIE_IDX_IRQ_STAT = 8'h18;    // Summary of asserted groups
    localparam int SIE_NUM_REGS = 3;                    // Pending/enable register pairs

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SIE_ALARM_LSB = 2;      // Alarm flags 1..6 in bits 2..7
    localparam int SIE_LOOP_BIT = 1;       // Loop-closure transition
    localparam int SIE_RTRIP_BIT = 0;      // Ring trip
    localparam int SIE_CALIB_BIT = 2;      // Common-mode calibration error
    localparam int SIE_INDIR_BIT = 1;      // Indirect access serviced
    localparam int SIE_TONE_BIT = 0;       // Tone detected
    localparam logic [7:0] SIE_CALIB_MASK = 8'h07;  // Implemented bits of third pair
    localparam logic [7:0] SIE_CALIB_MASK_NOTONE = 8'h06;  // Without tone decoder

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] SIE_RST_PEND = 8'h00;  // Pending flags after reset
    localparam logic [7:0] SIE_RST_EN = 8'h00;    // Enables after reset

    // ------------------------------------------------------------------
    // Bus types
    // ------------------------------------------------------------------
    localparam logic [1:0] SIE_HTRANS_NONSEQ = 2'h2;  // NONSEQ transfer
    localparam logic [1:0] SIE_HTRANS_SEQ = 2'h3;     // SEQ transfer

    // Address phase request captured for the data phase
    typedef struct packed {
        logic       valid;  // A transfer is in its data phase
        logic       write;  // Write transfer
        logic [7:0] index;  // Word index
    } sie_req_t;

    // Event strobes from the source detectors
    typedef struct packed {
        logic [7:0] timer;  // Timer events, same layout as timer pending
        logic [5:0] alarm;  // Power alarms 6..1
        logic       loop;   // Loop-closure transition
        logic       rtrip;  // Ring trip
        logic       hook_change;  // Hook state changed
        logic       calib_run;    // Common-mode calibration running
        logic       indir_done;   // Indirect access completed
        logic       tone;         // Tone detected
    } sie_events_t;

endpackage : sie_pkg

// >>> logic/sie_flag_bank.sv
// Purpose: Eight sticky pending flags with write-one-to-clear and enable gating
// Assumes: Set and clear strobes are one-cycle, synchronous to clk_i
// Notes: A set in the cycle of a clear wins; unimplemented bits stay zero
module sie_flag_bank (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [7:0] impl_mask_i,
    input wire logic [7:0] set_i,
    input wire logic [7:0] clr_i,
    input wire logic en_we_i,
    input wire logic [7:0] en_wdata_i,
    output logic [7:0] pend_o,
    output logic [7:0] en_o,
    output logic any_o
);
    import sie_pkg::*;

    logic [7:0] pend_reg;  // Sticky pending flags
    logic [7:0] en_reg;    // Enable bits

    // ------------------------------------------------------------------
    // Per-bit flags
    // ------------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_bit
            // Sticky flag, set wins over write-one clear
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    pend_reg[b] <= SIE_RST_PEND[b];
                end else if (ce_i) begin
                    if (!impl_mask_i[b]) begin
                        pend_reg[b] <= 1'b0;  // Reserved bit reads zero
                    end else if (set_i[b]) begin
                        pend_reg[b] <= 1'b1;
                    end else if (clr_i[b]) begin
                        pend_reg[b] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Enable register, reserved bits held at zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_reg <= SIE_RST_EN;
        end else if (ce_i && en_we_i) begin
            en_reg <= en_wdata_i & impl_mask_i;
        end
    end

    assign pend_o = pend_reg;
    assign en_o = en_reg;
    assign any_o = |(pend_reg & en_reg);

endmodule : sie_flag_bank

// >>> logic/sie_ahb_slave.sv
// Purpose: AHB-Lite slave front end, one-cycle registered data phase
// Assumes: Single word transfers, always OKAY, zero wait states
// Notes: Produces one-cycle write requests to the register file; reads are decoded there from the address phase
module sie_ahb_slave (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    output sie_pkg::sie_req_t req_o
);
    import sie_pkg::*;

    sie_req_t req_reg;  // Captured address phase

    // Capture address phase when the bus is ready
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_reg <= '0;
        end else if (ce_i && hready_i) begin
            req_reg.valid <= hsel_i && (htrans_i == SIE_HTRANS_NONSEQ
                                        || htrans_i == SIE_HTRANS_SEQ);
            req_reg.write <= hwrite_i;
            req_reg.index <= haddr_i[9:2];
        end
    end

    assign req_o = req_reg;

endmodule : sie_ahb_slave

// >>> logic/sie_irq_top.sv
// Purpose: Interrupt pending and enable registers of a telephone line interface
// Assumes: Event strobes synchronous to clk_i; AHB-Lite register access
// Notes: Interrupt output is a registered OR of enabled pending flags
//
// Overview of operation
// - Alarm six..one pending in bits 7..2
// - Loop-closure pending in bit 1
// - Ring-trip pending in bit 0
// - Writing one clears a pending flag
// - Hook change during calibration sets bit 2
// - Indirect access completion sets bit 1
// - Tone pending bit 0, zero without decoder
// - Timer enables occupy bits 7..0
// - Enable zero masks, one passes
// - Alarm, loop, ring-trip enables in second register
// - Calibration and indirect enables; 7..3 reserved
// - Tone enable bit 0, reserved without decoder
// - Timer pending flags bits 7..0, write-one clear
//
// Register access over AHB-Lite was left to the implementer.
module sie_irq_top #(
    parameter bit HAS_TONE = 1'b1  // Tone decoder present
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic [2:0] hsize_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    input wire sie_pkg::sie_events_t events_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic irq_o
);
    import sie_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sie_req_t req;                          // Data phase request
    logic [7:0] set_vec [SIE_NUM_REGS];     // Set strobes per bank
    logic [7:0] clr_vec [SIE_NUM_REGS];     // Clear strobes per bank
    logic [7:0] mask_vec [SIE_NUM_REGS];    // Implemented bits per bank
    logic [7:0] pend_vec [SIE_NUM_REGS];    // Pending flags per bank
    logic [7:0] en_vec [SIE_NUM_REGS];      // Enables per bank
    logic en_we [SIE_NUM_REGS];             // Enable write strobes
    logic [SIE_NUM_REGS-1:0] any_vec;       // Per-bank enabled pending
    logic [31:0] rdata_next;                // Read mux
    logic wr_now;                           // Write data phase
    logic rd_now;                           // Read address phase
    logic [7:0] rd_index;                   // Read index
    logic [7:0] wbyte;                      // Written byte

    // Unused bus inputs
    logic unused_ok;
    assign unused_ok = ^hsize_i;

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    sie_ahb_slave u_ahb (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hready_i(hready_i),
        .req_o(req)
    );

    assign wr_now = req.valid && req.write;
    assign wbyte = hwdata_i[7:0];
    assign rd_now = hsel_i && hready_i && !hwrite_i
                    && (htrans_i == SIE_HTRANS_NONSEQ || htrans_i == SIE_HTRANS_SEQ);
    assign rd_index = haddr_i[9:2];

    // ------------------------------------------------------------------
    // Event mapping into the three banks
    // ------------------------------------------------------------------
    always_comb begin
        set_vec[0] = events_i.timer;
        set_vec[1] = {events_i.alarm, events_i.loop, events_i.rtrip};
        set_vec[2] = 8'h00;
        set_vec[2][SIE_CALIB_BIT] = events_i.hook_change && events_i.calib_run;
        set_vec[2][SIE_INDIR_BIT] = events_i.indir_done;
        set_vec[2][SIE_TONE_BIT] = events_i.tone && HAS_TONE;
    end

    // Implemented bits per bank
    assign mask_vec[0] = 8'hff;
    assign mask_vec[1] = 8'hff;
    assign mask_vec[2] = HAS_TONE ? SIE_CALIB_MASK : SIE_CALIB_MASK_NOTONE;

    // Write decode: pending indices clear, enable indices store
    always_comb begin
        clr_vec[0] = (wr_now && req.index == SIE_IDX_TIMER_PEND) ? wbyte : 8'h00;
        clr_vec[1] = (wr_now && req.index == SIE_IDX_ALARM_PEND) ? wbyte : 8'h00;
        clr_vec[2] = (wr_now && req.index == SIE_IDX_CALIB_PEND) ? wbyte : 8'h00;
        en_we[0] = wr_now && req.index == SIE_IDX_TIMER_EN;
        en_we[1] = wr_now && req.index == SIE_IDX_ALARM_EN;
        en_we[2] = wr_now && req.index == SIE_IDX_CALIB_EN;
    end

    // ------------------------------------------------------------------
    // Flag banks
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < SIE_NUM_REGS; g++) begin : g_bank
            sie_flag_bank u_bank (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .ce_i(ce_i),
                .impl_mask_i(mask_vec[g]),
                .set_i(set_vec[g]),
                .clr_i(clr_vec[g]),
                .en_we_i(en_we[g]),
                .en_wdata_i(wbyte),
                .pend_o(pend_vec[g]),
                .en_o(en_vec[g]),
                .any_o(any_vec[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read mux, registered into the data phase
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;  // Unmapped reads return zero
        case (rd_index)
            SIE_IDX_TIMER_PEND: rdata_next[7:0] = pend_vec[0];
            SIE_IDX_ALARM_PEND: rdata_next[7:0] = pend_vec[1];
            SIE_IDX_CALIB_PEND: rdata_next[7:0] = pend_vec[2];
            SIE_IDX_TIMER_EN: rdata_next[7:0] = en_vec[0];
            SIE_IDX_ALARM_EN: rdata_next[7:0] = en_vec[1];
            SIE_IDX_CALIB_EN: rdata_next[7:0] = en_vec[2];
            SIE_IDX_IRQ_STAT: rdata_next[SIE_NUM_REGS-1:0] = any_vec;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (ce_i && rd_now) begin
            hrdata_o <= rdata_next;
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // Interrupt output from enabled pending flags
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |any_vec;
        end
    end

endmodule : sie_irq_top

// >>> verification/sie_irq_properties.sv
// Purpose: Port-level checks on the interrupt status/enable block
// Assumes: ce_i high; enables shadowed here from bus writes
// Notes: Bound into every sie_irq_top instance
module sie_irq_properties #(
    parameter bit HAS_TONE = 1'b1  // Tone decoder present
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic [2:0] hsize_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    input wire sie_pkg::sie_events_t events_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic irq_o
);
    import sie_pkg::*;
    logic tk;  // Address phase taken
    logic wr_dp;  // Write data phase in progress
    logic ev_any;  // Any event that sets a flag
    logic [31:0] a_dp;  // Address of the data phase
    logic [7:0] en_t, en_a, en_c;  // Shadow enables
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    assign tk = hsel_i && htrans_i[1] && hready_i && ce_i;
    assign ev_any = |{events_i.timer, events_i.alarm, events_i.loop, events_i.rtrip,
        events_i.hook_change && events_i.calib_run, events_i.indir_done, events_i.tone};
    // Shadow of the enable registers, updated at the end of a write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {wr_dp, a_dp, en_t, en_a, en_c} <= '0;
        end else begin
            wr_dp <= tk && hwrite_i;
            a_dp <= haddr_i;
            if (wr_dp && a_dp == 32'h54) en_t <= hwdata_i[7:0];
            if (wr_dp && a_dp == 32'h58) en_a <= hwdata_i[7:0];
            if (wr_dp && a_dp == 32'h5c) en_c <= hwdata_i[7:0];
        end
    end
    sequence s_rd_take;
        tk && !hwrite_i;
    endsequence
    sequence s_rd_unmapped;
        s_rd_take ##0 (haddr_i < 32'h48 || (haddr_i > 32'h60 && haddr_i < 32'h400));
    endsequence
    sequence s_rd_calib;
        s_rd_take ##0 (haddr_i == 32'h50 || haddr_i == 32'h5c);
    endsequence
    chk_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    chk_unmapped_zero: assert property (s_rd_unmapped |=> hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_rsvd_zero: assert property (s_rd_calib |=> hrdata_o[31:3] == 29'h0 && (HAS_TONE || !hrdata_o[0]))
        else $error("reserved bits read nonzero");
    chk_read_hold: assert property (!(tk && !hwrite_i) |=> $stable(hrdata_o))
        else $error("read data changed without a read");
    chk_timer_irq: assert property (|(events_i.timer & en_t) && !wr_dp |-> ##2 irq_o)
        else $error("enabled timer event gave no irq");
    chk_alarm_irq: assert property (|({events_i.alarm, events_i.loop, events_i.rtrip} & en_a)
        && !wr_dp |-> ##2 irq_o)
        else $error("enabled alarm event gave no irq");
    chk_calib_irq: assert property (|({events_i.hook_change && events_i.calib_run,
        events_i.indir_done, events_i.tone && HAS_TONE} & en_c[2:0]) && !wr_dp
        |-> ##2 irq_o)
        else $error("enabled calibration event gave no irq");
    chk_irq_cause: assert property ($rose(irq_o) |-> $past(ev_any, 2) || $past(wr_dp, 2))
        else $error("irq rose without a cause");
    chk_irq_fall: assert property ($fell(irq_o) |-> $past(wr_dp, 2))
        else $error("irq fell without a write");
endmodule : sie_irq_properties

bind sie_irq_top sie_irq_properties #(.HAS_TONE(HAS_TONE)) u_chk (.clk_i, .reset_n_i, .ce_i,
    .hsel_i, .haddr_i, .htrans_i, .hsize_i, .hwrite_i, .hready_i, .hwdata_i, .events_i,
    .hrdata_o, .hreadyout_o, .hresp_o, .irq_o);

// >>> verification/sie_host_model.sv
// Purpose: Host side AHB-Lite master for the interrupt block
// Assumes: Called just after a rising edge
// Notes: Single word transfers; waits on hready without a bound
module sie_host_model (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic [2:0] hsize_o,
    output logic hwrite_o,
    output logic [31:0] hwdata_o
);
    import sie_pkg::*;
    initial {hsel_o, haddr_o, htrans_o, hwrite_o, hwdata_o} = '0;
    assign hsize_o = 3'h2;  // Whole word only
    // One transfer: address phase, then data phase
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        hsel_o <= 1'b1;
        haddr_o <= a;
        hwrite_o <= w;
        htrans_o <= SIE_HTRANS_NONSEQ;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'h0;
        hwdata_o <= d;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        q = hrdata_i;
        hwdata_o <= ~d;  // Released data bus shows no stale value
    endtask : xfer
endmodule : sie_host_model

// >>> verification/tb_slic_interrupt_status_enable.sv
// Purpose: Self-checking bench for the interrupt status/enable block
// Assumes: Tone decoder present; ce_i held high
// Notes: Integer model of flags and enables checked on every read
module tb_slic_interrupt_status_enable;
    timeunit 1ns;
    timeprecision 1ns;
    import sie_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic hsel_i, hwrite_i, hreadyout_o, hresp_o, irq_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    sie_events_t events_i = '0;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 73;
    int pend [3] = '{0, 0, 0};  // Model pending flags
    int en [3] = '{0, 0, 0};  // Model enables
    always #5 clk_i = ~clk_i;
    sie_irq_top #(.HAS_TONE(1'b1)) u_dut (.clk_i, .reset_n_i, .ce_i, .hsel_i, .haddr_i,
        .htrans_i, .hsize_i, .hwrite_i, .hready_i(hreadyout_o), .hwdata_i, .events_i,
        .hrdata_o, .hreadyout_o, .hresp_o, .irq_o);
    sie_host_model u_host (.clk_i, .hready_i(hreadyout_o), .hrdata_i(hrdata_o),
        .hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i), .hsize_o(hsize_i),
        .hwrite_o(hwrite_i), .hwdata_o(hwdata_i));
    // Expected read value of a word index
    function automatic int exp_of(input int idx);
        int s;
        s = 0;
        for (int g = 0; g < 3; g++) s |= int'((pend[g] & en[g]) != 0) << g;
        if (idx >= 8'h12 && idx <= 8'h14) return pend[idx - 8'h12];
        if (idx >= 8'h15 && idx <= 8'h17) return en[idx - 8'h15];
        return (idx == 8'h18) ? s : 0;
    endfunction : exp_of
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t read %h exp %h", $time, got, exp);
        end
    endtask : cmp_rd
    task automatic cmp_irq(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t irq %h exp %h", $time, got, exp);
        end
    endtask : cmp_irq
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    // Register write; model follows clear and enable layout
    task automatic wr(input int idx, input int d);
        u_host.xfer(32'(idx * 4), 1'b1, 32'(d), q);
        if (idx >= 8'h12 && idx <= 8'h14) pend[idx - 8'h12] &= ~d;
        if (idx >= 8'h15 && idx <= 8'h17) en[idx - 8'h15] = d & ((idx == 8'h17) ? 7 : 255);
    endtask : wr
    // Read every index around the map, then the irq level
    task automatic check_all;
        for (int idx = 8'h10; idx < 8'h1a; idx++) begin
            u_host.xfer(32'(idx * 4), 1'b0, 32'(idx), q);
            cmp_rd(q, 32'(exp_of(idx)));
        end
        cmp_irq(irq_o, exp_of(8'h18) != 0);
    endtask : check_all
    // One-cycle event strobe and its effect on the model
    task automatic pulse(input sie_events_t e);
        events_i <= e;
        @(posedge clk_i);
        events_i <= '0;
        pend[0] |= e.timer;
        pend[1] |= {e.alarm, e.loop, e.rtrip};
        pend[2] |= {e.hook_change & e.calib_run, e.indir_done, e.tone};
    endtask : pulse
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        check_all;
        wr(8'h11, 255);
        for (int i = 0; i < 20; i++) begin
            pulse(sie_events_t'(20'h1 << i));
            check_all;
        end
        pulse(sie_events_t'(20'hc));
        for (int g = 0; g < 3; g++) wr(8'h15 + g, -1);
        check_all;
        for (int g = 0; g < 24; g++) begin
            wr(8'h12 + g / 8, 1 << (g % 8));
            check_all;
        end
        repeat (150) begin
            pulse(sie_events_t'($random(seed)));
            wr(8'h12 + {$random(seed)} % 7, $random(seed));
            check_all;
        end
        give_verdict;
    end
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        error_cnt++;
        give_verdict;
    end
endmodule : tb_slic_interrupt_status_enable
